// File: core/ucg_pkg.sv
package ucg_pkg;

    // Baud divisor width and reset value
    localparam int          DIV_W         = 12;
    localparam logic [11:0] DIV_RST       = 12'h000;
    // Last sample index: 16, 8 or 2 samples
    localparam logic [3:0]  OVS_NORM_LAST = 4'hF;
    localparam logic [3:0]  OVS_DBL_LAST  = 4'h7;
    localparam logic [3:0]  OVS_SYNC_LAST = 4'h1;
    // Centre sample in each async rate
    localparam logic [3:0]  MID_NORM      = 4'h8;
    localparam logic [3:0]  MID_DBL       = 4'h4;
    // Idle line level and buffer reset state
    localparam logic        TXD_IDLE      = 1'b1;
    localparam logic        TXBUF_EMPTY   = 1'b1;
    localparam logic        RXD_IDLE      = 1'b1;
    // Parity mode field: bit 1 enables, bit 0 picks odd
    localparam int          PM_EN_BIT     = 1;
    localparam int          PM_ODD_BIT    = 0;
    // Character size code for nine data bits
    localparam logic [2:0]  CS_NINE       = 3'h7;
    localparam logic [3:0]  LEN_NINE      = 4'h9;
    localparam logic [3:0]  LEN_BASE      = 4'h5;
    // Receive entry: frame err, parity err, data
    localparam int          RXE_W         = 11;

    // Transmit frame sequence
    typedef enum logic [2:0] {
        TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP1, TX_STOP2
    } ucg_tx_st_t;

    // Receive frame sequence
    typedef enum logic [2:0] {
        RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP
    } ucg_rx_st_t;

    // Data bits from the size code
    function automatic logic [3:0] ucg_char_len(input logic [2:0] sz);
        if (sz == CS_NINE) begin
            return LEN_NINE;
        end
        return LEN_BASE + {2'h0, sz[1:0]};
    endfunction : ucg_char_len

    // Parity over len bits, inverted when odd
    function automatic logic ucg_par(input logic [8:0] d,
                                     input logic [3:0] len,
                                     input logic       odd);
        logic p;
        p = odd;
        for (int i = 0; i < 9; i++) begin
            if (i < int'(len)) begin
                p = p ^ d[i];
            end
        end
        return p;
    endfunction : ucg_par

endpackage : ucg_pkg

// File: core/ucg_sync3.sv
`timescale 1ns/1ps
module ucg_sync3 #(
    parameter logic RESET_LEVEL = 1'b0
) (
    // Clock and reset
    input  wire logic mclk,
    input  wire logic arst_n,
    // Pin side and clean level
    input  wire logic async_in,
    output logic      level_out
);
    import ucg_pkg::*;

    // Three stages and the accepted level
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic q;
    } ucg_sync_t;

    ucg_sync_t r;  // Registered state
    ucg_sync_t n;  // Next state

    // Accept a level once stages two and three agree
    always_comb begin
        n    = r;
        n.s1 = async_in;
        n.s2 = r.s1;
        n.s3 = r.s2;
        // One-cycle glitches never pass
        if (r.s2 == r.s3) begin
            n.q = r.s3;
        end
    end

    // State register
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            r <= {4{RESET_LEVEL}};
        end else begin
            r <= n;
        end
    end

    assign level_out = r.q;

endmodule : ucg_sync3

// File: core/ucg_rxbuf.sv
`timescale 1ns/1ps
module ucg_rxbuf (
    // Clock and reset
    input  wire logic                      mclk,
    input  wire logic                      arst_n,
    // Write side
    input  wire logic                      push,
    input  wire logic [ucg_pkg::RXE_W-1:0] push_data,
    output logic                           full,
    // Read side; head is registered
    input  wire logic                      pop,
    output logic                           valid,
    output logic [ucg_pkg::RXE_W-1:0]      head
);
    import ucg_pkg::*;

    // Two entries, entry zero oldest
    typedef struct packed {
        logic [RXE_W-1:0] e0;
        logic [RXE_W-1:0] e1;
        logic [1:0]       cnt;
        logic             valid;
        logic             full;
    } ucg_rxb_t;

    ucg_rxb_t r;  // Registered state
    ucg_rxb_t n;  // Next state

    // Pop first: push and pop on full both land
    always_comb begin
        n = r;
        if (pop && r.cnt != 2'h0) begin
            n.e0  = r.e1;
            n.cnt = r.cnt - 2'h1;
        end
        if (push && n.cnt != 2'h2) begin
            if (n.cnt == 2'h0) begin
                n.e0 = push_data;
            end else begin
                n.e1 = push_data;
            end
            n.cnt = n.cnt + 2'h1;
        end
        n.valid = (n.cnt != 2'h0);
        n.full  = (n.cnt == 2'h2);
    end

    // State register
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign full  = r.full;
    assign valid = r.valid;
    assign head  = r.e0;

endmodule : ucg_rxbuf

// File: core/ucg_top.sv
// How it works
// R1: Four clock modes.
// R2: Mode bit picks async or sync.
// R3: Double speed only in async.
// R4: Pin direction picks master or slave.
// R5: Clock pin idle in async.
// R6: Slave clock synchronised first.
// R7: Generator idle in slave mode.
// R8: Count down; reload at zero, low write.
// R9: Tick at zero, every divisor+1 clocks.
// R10: Transmitter divides ticks by 16, 8 or 2.
// R11: Receiver uses 16 or 8 sample states in async; sync takes one sample per clock, on the sample edge only.
// R12: Twelve-bit divisor from two bytes.
// R13: Write buffer gives gapless frames.
// R14: Two-entry receive buffer.
// R15: Flag framing, overrun and parity errors.
// R16: Three request flags.
// R17: Five to nine data bits, one or two stops.
// R18: Generate and check odd or even parity.
// R19: Filter noise; reject short start bits.
// R20: Power reduction must be clear.
// R21: Slave clock below quarter system clock.
// R22: Polarity picks change and sample edges.
// R23: High byte write waits for next reload.
`timescale 1ns/1ps
module ucg_top (
    // Clock and reset
    input  wire logic       mclk,
    input  wire logic       arst_n,
    // Mode and frame configuration
    input  wire logic       sync_mode_select,
    input  wire logic       double_speed_bit,
    input  wire logic       transfer_clock_pin_direction,
    input  wire logic       sync_clock_polarity,
    input  wire logic       serial_power_reduction,
    input  wire logic [2:0] char_size,
    input  wire logic [1:0] parity_mode,
    input  wire logic       stop_two,
    input  wire logic       tx_enable,
    input  wire logic       rx_enable,
    // Baud divisor bytes
    input  wire logic       baud_divisor_low_wr,
    input  wire logic       baud_divisor_high_wr,
    input  wire logic [7:0] divisor_wdata,
    // Transmit data
    input  wire logic       tx_data_wr,
    input  wire logic [8:0] tx_data,
    input  wire logic       tx_complete_clr,
    // Receive data
    input  wire logic       rx_data_rd,
    output logic [8:0]      rx_data,
    output logic            rx_frame_err,
    output logic            rx_parity_err,
    output logic            rx_overrun,
    // Request levels
    output logic            rx_complete,
    output logic            tx_data_empty,
    output logic            tx_complete,
    // Serial pins
    output logic            txd,
    input  wire logic       rxd,
    input  wire logic       xck_in,
    output logic            xck_out,
    output logic            xck_oe
);
    import ucg_pkg::*;

    // Whole block state
    typedef struct packed {
        logic [DIV_W-1:0] div;     // Divisor value
        logic [DIV_W-1:0] cnt;     // Down-counter
        logic             tick;    // Generator output pulse
        logic             xck;     // Master clock level
        logic             xck_oe;  // Clock pin drive
        logic             xprev;   // Last slave clock level
        logic [3:0]       txpre;   // Transmit prescaler
        ucg_tx_st_t       txs;     // Transmit state
        logic [8:0]       txsh;    // Transmit shifter
        logic [3:0]       txn;     // Bits sent
        logic             txpar;   // Parity to send
        logic [8:0]       txbuf;   // Write buffer
        logic             txempty; // Write buffer empty
        logic             txd;     // Line level
        logic             txc;     // Transmission complete
        ucg_rx_st_t       rxs;     // Receive state
        logic [3:0]       rxsamp;  // Sample index in bit
        logic [1:0]       vote;    // Earlier centre samples
        logic [8:0]       rxsh;    // Receive shifter
        logic [3:0]       rxn;     // Bits taken
        logic             rxpe;    // Parity mismatch seen
        logic             ovr;     // Overrun flag
    } ucg_state_t;

    ucg_state_t r;  // Registered state
    ucg_state_t n;  // Next state

    // Clean pin levels
    logic rxd_s;    // Filtered receive line
    logic xck_s;    // Synchronised slave clock

    // Mode decode
    logic       master;    // Synchronous, internal clock
    logic       slave;     // Synchronous, external clock
    logic       brg_run;   // Baud generator active
    logic       tx_en;     // Transmitter usable
    logic       rx_en;     // Receiver usable
    logic [3:0] txlast;    // Prescaler wrap value
    logic [3:0] ovs_last;  // Receive sample wrap value
    logic [3:0] mid;       // Centre sample
    logic [3:0] len;       // Data bits per character
    logic       pen;       // Parity enabled
    logic       podd;      // Odd parity

    // Clock edges and bit events
    logic xrise;      // Transfer clock rising
    logic xfall;      // Transfer clock falling
    logic change_ev;  // Edge on which data changes
    logic sample_ev;  // Edge on which data is sampled
    logic tx_tick;    // Transmit bit clock
    logic rx_ev;      // One receive bit decided
    logic rx_val;     // Its value
    logic rx_push;    // Character complete

    // Receive buffer link
    logic                 rxb_full;
    logic [RXE_W-1:0]     rxb_head;
    logic                 rxb_valid;

    // R19 receive filter
    ucg_sync3 #(
        .RESET_LEVEL (RXD_IDLE)
    ) u_rxd_sync (
        .mclk      (mclk),
        .arst_n    (arst_n),
        .async_in  (rxd),
        .level_out (rxd_s)
    );

    // R6 R21 slave clock synchroniser
    ucg_sync3 #(
        .RESET_LEVEL (1'b0)
    ) u_xck_sync (
        .mclk      (mclk),
        .arst_n    (arst_n),
        .async_in  (xck_in),
        .level_out (xck_s)
    );

    // R14 two-entry receive buffer
    ucg_rxbuf u_rxbuf (
        .mclk      (mclk),
        .arst_n    (arst_n),
        .push      (rx_push),
        .push_data ({!rx_val, r.rxpe, r.rxsh}),
        .full      (rxb_full),
        .pop       (rx_data_rd),
        .valid     (rxb_valid),
        .head      (rxb_head)
    );

    // R1 R2 R4 mode decode
    assign master  = sync_mode_select && transfer_clock_pin_direction;
    assign slave   = sync_mode_select && !transfer_clock_pin_direction;
    // R20 power reduction stops tx and rx
    assign tx_en   = tx_enable && !serial_power_reduction;
    assign rx_en   = rx_enable && !serial_power_reduction;
    // R7 generator idle in slave mode
    assign brg_run = !serial_power_reduction && !slave;

    // R3 double speed only in async
    assign txlast   = double_speed_bit ? OVS_DBL_LAST : OVS_NORM_LAST;
    assign mid      = double_speed_bit ? MID_DBL : MID_NORM;
    // R11 receiver sample states: 16, 8 or 2
    assign ovs_last = sync_mode_select ? OVS_SYNC_LAST : txlast;

    // R17 frame format
    assign len  = ucg_char_len(char_size);
    assign pen  = parity_mode[PM_EN_BIT];
    assign podd = parity_mode[PM_ODD_BIT];

    // Transfer clock edges, master or slave
    always_comb begin
        if (master) begin
            xrise = r.tick && !r.xck;
            xfall = r.tick && r.xck;
        end else begin
            xrise = slave && xck_s && !r.xprev;
            xfall = slave && !xck_s && r.xprev;
        end
    end

    // R22 polarity selects change and sample edge
    assign change_ev = sync_clock_polarity ? xfall : xrise;
    assign sample_ev = sync_clock_polarity ? xrise : xfall;

    // R10 bit clock: prescaler wrap or clock edge
    assign tx_tick = sync_mode_select ? change_ev
                                      : (r.tick && r.txpre == txlast);

    // R19 majority of three centre samples in async; one sample in sync
    always_comb begin
        if (sync_mode_select) begin
            rx_ev  = sample_ev && rx_en;
            rx_val = rxd_s;
        end else begin
            rx_ev  = r.tick && rx_en && r.rxs != RX_IDLE
                     && r.rxsamp == mid + 4'h1;
            rx_val = (r.vote[1] & r.vote[0]) | (r.vote[1] & rxd_s)
                     | (r.vote[0] & rxd_s);
        end
    end

    // Character ends on its first stop bit
    assign rx_push = rx_ev && r.rxs == RX_STOP;

    // Next-state logic
    always_comb begin
        logic tx_load;  // Move write buffer into shifter
        logic tx_done;  // Last stop bit finished
        tx_load = 1'b0;
        tx_done = 1'b0;
        n       = r;
        n.tick  = 1'b0;

        // R8 R9 down-counter; tick and reload on zero
        if (brg_run) begin
            if (r.cnt == '0) begin
                n.cnt  = r.div;
                n.tick = 1'b1;
            end else begin
                n.cnt = r.cnt - 12'h001;
            end
        end
        // R23 high byte stored, no reload
        if (baud_divisor_high_wr) begin
            n.div[DIV_W-1:8] = divisor_wdata[3:0];
        end
        // R8 R12 low byte write reloads counter
        if (baud_divisor_low_wr) begin
            n.div[7:0] = divisor_wdata;
            n.cnt      = {r.div[DIV_W-1:8], divisor_wdata};
        end

        // R4 R5 clock pin driven only in master mode
        n.xck_oe = master;
        n.xprev  = xck_s;
        if (!master) begin
            n.xck = 1'b0;
        end else if (r.tick) begin
            n.xck = !r.xck;
        end

        // R10 asynchronous transmit prescaler
        if (sync_mode_select) begin
            n.txpre = 4'h0;
        end else if (r.tick) begin
            n.txpre = (r.txpre == txlast) ? 4'h0 : r.txpre + 4'h1;
        end

        // R13 write buffer takes data only while empty
        if (tx_data_wr && r.txempty) begin
            n.txbuf   = tx_data;
            n.txempty = 1'b0;
        end

        // Transmit frame walk
        if (!tx_en) begin
            n.txs = TX_IDLE;
            n.txd = TXD_IDLE;
        end else if (tx_tick) begin
            unique case (r.txs)
                TX_IDLE: begin
                    tx_load = !r.txempty;
                end
                TX_START: begin
                    n.txd  = r.txsh[0];
                    n.txsh = r.txsh >> 1;
                    n.txn  = 4'h1;
                    n.txs  = TX_DATA;
                end
                // R17 data count from the size code
                TX_DATA: begin
                    if (r.txn == len) begin
                        n.txd = pen ? r.txpar : TXD_IDLE;
                        n.txs = pen ? TX_PAR : TX_STOP1;
                    end else begin
                        n.txd  = r.txsh[0];
                        n.txsh = r.txsh >> 1;
                        n.txn  = r.txn + 4'h1;
                    end
                end
                TX_PAR: begin
                    n.txd = TXD_IDLE;
                    n.txs = TX_STOP1;
                end
                // R17 one or two stop bits
                TX_STOP1: begin
                    if (stop_two) begin
                        n.txs = TX_STOP2;
                    end else begin
                        tx_done = 1'b1;
                    end
                end
                TX_STOP2: begin
                    tx_done = 1'b1;
                end
            endcase
        end

        // R13 waiting character follows with no gap
        if (tx_done) begin
            tx_load = !r.txempty;
            n.txs   = TX_IDLE;
        end
        if (tx_load) begin
            n.txsh    = r.txbuf;
            // R18 parity computed at load
            n.txpar   = ucg_par(r.txbuf, len, podd);
            n.txempty = TXBUF_EMPTY;
            n.txd     = 1'b0;
            n.txs     = TX_START;
        end

        // R16 complete flag; set beats clear
        n.txc = (r.txc && !tx_complete_clr) || (tx_done && !tx_load);

        // R11 R19 async start detect, sample count
        if (!rx_en) begin
            n.rxs = RX_IDLE;
        end else if (!sync_mode_select && r.tick) begin
            if (r.rxs == RX_IDLE) begin
                if (!rxd_s) begin
                    n.rxs    = RX_START;
                    n.rxsamp = 4'h1;
                end
            end else begin
                n.rxsamp = (r.rxsamp == ovs_last) ? 4'h0
                                                  : r.rxsamp + 4'h1;
                if (r.rxsamp == mid - 4'h1 || r.rxsamp == mid) begin
                    n.vote = {r.vote[0], rxd_s};
                end
            end
        end

        // Receive frame walk
        if (rx_ev) begin
            unique case (r.rxs)
                // Sync start bit on a sample edge
                RX_IDLE: begin
                    if (!rx_val) begin
                        n.rxs  = RX_DATA;
                        n.rxn  = 4'h0;
                        n.rxsh = '0;
                        n.rxpe = 1'b0;
                    end
                end
                // R19 start bit gone high again is false
                RX_START: begin
                    n.rxs  = rx_val ? RX_IDLE : RX_DATA;
                    n.rxn  = 4'h0;
                    n.rxsh = '0;
                    n.rxpe = 1'b0;
                end
                RX_DATA: begin
                    n.rxsh[r.rxn] = rx_val;
                    n.rxn         = r.rxn + 4'h1;
                    if (r.rxn == len - 4'h1) begin
                        n.rxs = pen ? RX_PAR : RX_STOP;
                    end
                end
                // R18 R15 parity checked against the data
                RX_PAR: begin
                    n.rxpe = rx_val != ucg_par(r.rxsh, len, podd);
                    n.rxs  = RX_STOP;
                end
                // R15 framing error kept with data
                RX_STOP: begin
                    n.rxs = RX_IDLE;
                end
            endcase
        end

        // R15 overrun when full; read beats set
        n.ovr = (r.ovr && !rx_data_rd)
                || (rx_push && rxb_full && !rx_data_rd);
    end

    // State register
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            r         <= '0;
            r.div     <= DIV_RST;
            r.txd     <= TXD_IDLE;
            r.txempty <= TXBUF_EMPTY;
        end else begin
            r <= n;
        end
    end

    // Outputs straight from registers
    assign txd           = r.txd;
    assign xck_out       = r.xck;
    assign xck_oe        = r.xck_oe;
    assign tx_data_empty = r.txempty;
    assign tx_complete   = r.txc;
    assign rx_overrun    = r.ovr;
    // R16 receive complete while buffer not empty
    assign rx_complete   = rxb_valid;
    assign rx_data       = rxb_head[8:0];
    assign rx_parity_err = rxb_head[9];
    assign rx_frame_err  = rxb_head[10];

endmodule : ucg_top

// File: verif/ucg_top_properties.sv
`timescale 1ns/1ps
module ucg_top_properties (
    // Clock and reset
    input wire logic       mclk,
    input wire logic       arst_n,
    // Mode and strobes
    input wire logic       sync_mode_select,
    input wire logic       transfer_clock_pin_direction,
    input wire logic       serial_power_reduction,
    input wire logic       tx_enable,
    input wire logic       tx_data_wr,
    input wire logic       tx_complete_clr,
    input wire logic       rx_data_rd,
    // Watched outputs
    input wire logic [8:0] rx_data,
    input wire logic       rx_overrun,
    input wire logic       rx_complete,
    input wire logic       tx_data_empty,
    input wire logic       tx_complete,
    input wire logic       txd,
    input wire logic       xck_oe
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);
    // Master mode from the inputs
    wire master = sync_mode_select && transfer_clock_pin_direction;
    // Write taken by an enabled transmitter
    sequence s_take;
        tx_data_wr && tx_data_empty && tx_enable && !serial_power_reduction;
    endsequence
    // Start bit within a clock of the load
    sequence s_start;
        ##[0:1] !txd;
    endsequence
    a_oe_master_only: assert property (
        xck_oe |-> $past(master)) else $error("pin driven off master");
    a_oe_master_on: assert property (
        master && $past(master) && !$past(serial_power_reduction) |-> xck_oe)
        else $error("pin not driven");
    a_tx_take: assert property (
        s_take |=> !tx_data_empty) else $error("write not taken");
    a_tx_start: assert property (
        $rose(tx_data_empty) |-> s_start) else $error("no start bit");
    a_txc_sticky: assert property (
        tx_complete && !tx_complete_clr |=> tx_complete) else $error("txc lost");
    a_txc_done: assert property (
        $rose(tx_complete) |-> tx_data_empty && txd) else $error("early txc");
    a_ovr_sticky: assert property (
        rx_overrun && !rx_data_rd |=> rx_overrun) else $error("overrun lost");
    a_rx_hold: assert property (
        rx_complete && !rx_data_rd |=> rx_complete && $stable(rx_data))
        else $error("rx head moved");
endmodule : ucg_top_properties

bind ucg_top ucg_top_properties u_ucg_top_properties (.*);

// File: verif/ucg_partner.sv
`timescale 1ns/1ps
module ucg_partner (
    // Clock
    input wire logic mclk,
    // Line into the block, idle high
    output logic     rxd
);
    initial rxd = 1'b1;
    // Hold a level for n clocks, then settle past the edge
    task automatic drive(input logic v, input int n);
        rxd = v;
        repeat (n) @(posedge mclk);
        #1;
    endtask : drive
    task automatic send(input logic [8:0] d, input int len,
                        input logic pe, po, bp, bs, input int bt);
        logic p;
        p = po ^ bp;
        drive(1'b0, bt);
        for (int i = 0; i < len; i++) begin
            p = p ^ d[i];
            drive(d[i], bt);
        end
        if (pe) begin
            drive(p, bt);
        end
        drive(!bs, bt);
        rxd = 1'b1;
    endtask : send
endmodule : ucg_partner

// File: verif/ucg_top_tb.sv
`timescale 1ns/1ps
module ucg_top_tb;
    import ucg_pkg::*;
    // Mode: 0 normal, 1 double, 2 master, 3 master+double
    typedef struct {logic [1:0] md; logic [11:0] dv; logic [2:0] cs;
        logic [1:0] pm; logic st; logic [8:0] d; int bt;} ucg_row_t;
    // Inputs and expected bit time in clocks
    ucg_row_t rows [6] = '{'{2'h0, 12'h001, 3'h3, 2'h2, 1'b0, 9'h0A5, 32},
        '{2'h1, 12'h002, 3'h0, 2'h3, 1'b1, 9'h013, 24},
        '{2'h2, 12'h004, 3'h7, 2'h0, 1'b0, 9'h1C3, 10},
        '{2'h3, 12'h003, 3'h2, 2'h3, 1'b0, 9'h05A, 8},
        '{2'h0, 12'h000, 3'h1, 2'h2, 1'b1, 9'h02C, 16},
        '{2'h0, 12'h003, 3'h3, 2'h2, 1'b0, 9'h03C, 64}};
    ucg_row_t   r;
    logic       mclk, arst_n, sync_mode_select, double_speed_bit;
    logic       transfer_clock_pin_direction, sync_clock_polarity;
    logic       serial_power_reduction, stop_two, tx_enable, rx_enable;
    logic [2:0] char_size;
    logic [1:0] parity_mode;
    logic       baud_divisor_low_wr, baud_divisor_high_wr, tx_data_wr;
    logic [7:0] divisor_wdata;
    logic [8:0] tx_data, rx_data;
    logic       tx_complete_clr, rx_data_rd, rx_frame_err, rx_parity_err;
    logic       rx_overrun, rx_complete, tx_data_empty, tx_complete;
    logic       txd, rxd, xck_in, xck_out, xck_oe;
    int         fail_count, n_tests;
    ucg_top     u_ucg_top (.*);
    ucg_partner u_ucg_partner (.mclk(mclk), .rxd(rxd));
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    // Inputs move 1 ns after an edge
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : tick
    task automatic chk(input logic [10:0] seen, exp, input string m);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch t=%0t %s seen %h exp %h", $time, m, seen, exp);
        end
    endtask : chk
    // Mode, frame, divisor: high byte, then low
    task automatic setup(input ucg_row_t s);
        {sync_mode_select, transfer_clock_pin_direction} = {2{s.md[1]}};
        double_speed_bit = s.md[0];
        sync_clock_polarity = s.md == 2'h3;
        {char_size, parity_mode, stop_two} = {s.cs, s.pm, s.st};
        divisor_wdata = {4'h0, s.dv[11:8]};
        baud_divisor_high_wr = 1'b1;
        tick(1);
        {baud_divisor_high_wr, baud_divisor_low_wr} = 2'b01;
        divisor_wdata = s.dv[7:0];
        tick(1);
        baud_divisor_low_wr = 1'b0;
    endtask : setup
    task automatic wr_tx(input logic [8:0] d);
        tx_data = d;
        tx_data_wr = 1'b1;
        tick(1);
        tx_data_wr = 1'b0;
    endtask : wr_tx
    task automatic pop;
        rx_data_rd = 1'b1;
        tick(1);
        rx_data_rd = 0;
        tick(2);
    endtask : pop
    // Sample txd mid-bit from its start edge
    task automatic frame(input ucg_row_t f, input int bound);
        int   n;
        logic p;
        n = 0;
        p = f.pm[0];
        while (txd !== 1'b0 && n < bound) begin
            tick(1);
            n++;
        end
        n = (f.cs == CS_NINE) ? 9 : 5 + int'(f.cs[1:0]);
        tick(f.bt / 2);
        chk(txd, 1'b0, "start");
        for (int i = 0; i < n; i++) begin
            tick(f.bt);
            p = p ^ f.d[i];
            chk(txd, f.d[i], "data");
        end
        tick(f.bt);
        chk(txd, f.pm[1] ? p : 1'b1, "parity");
    endtask : frame
    task automatic final_report;
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : final_report
    initial begin
        {fail_count, n_tests, arst_n, serial_power_reduction} = '0;
        {tx_complete_clr, rx_data_rd, xck_in, tx_data, tx_data_wr} = '0;
        {tx_enable, rx_enable} = 2'b11;
        setup(rows[0]);
        tick(20);
        arst_n = 1'b1;
        foreach (rows[k]) begin
            setup(rows[k]);
            wr_tx(rows[k].d);
            frame(rows[k], 4 * rows[k].bt);
            chk(xck_oe, rows[k].md[1], "pin drive");
            tick(3 * rows[k].bt);
            chk(tx_complete, 1'b1, "tx done");
            tx_complete_clr = 1'b1;
            tick(1);
            tx_complete_clr = 1'b0;
            tick(1);
            chk(tx_complete, 1'b0, "tx clear");
            $display("test row %0d done", k);
        end
        // Second write while shifting, third refused
        r = rows[4];
        setup(r);
        wr_tx(r.d);
        frame(r, 64);
        wr_tx(9'h013);
        tick(1);
        wr_tx(9'h1FF);
        r.d = 9'h013;
        frame(r, 64);
        tick(5 * r.bt);
        chk(tx_complete, 1'b1, "refused write");
        $display("test back to back done");
        // Third unread frame dropped; bad parity, stop
        setup(rows[5]);
        u_ucg_partner.send(9'h03C, 8, 1'b1, 1'b0, 1'b0, 1'b0, 64);
        u_ucg_partner.send(9'h055, 8, 1'b1, 1'b0, 1'b1, 1'b0, 64);
        u_ucg_partner.send(9'h00F, 8, 1'b1, 1'b0, 1'b0, 1'b0, 64);
        tick(10);
        chk(rx_overrun, 1'b1, "overrun");
        chk({rx_parity_err, rx_data}, 10'h03C, "first char");
        pop;
        chk({rx_parity_err, rx_data}, 10'h255, "parity err");
        chk(rx_overrun, 1'b0, "overrun clear");
        pop;
        chk(rx_complete, 1'b0, "drained");
        u_ucg_partner.send(9'h081, 8, 1'b1, 1'b0, 1'b0, 1'b1, 64);
        tick(10);
        chk({rx_frame_err, rx_data}, 10'h281, "frame err");
        pop;
        // A low pulse under half a bit is no start
        u_ucg_partner.drive(1'b0, 12);
        u_ucg_partner.drive(1'b1, 800);
        chk(rx_complete, 1'b0, "false start");
        $display("test receive done");
        // Reset in mid-frame from master mode
        setup(rows[2]);
        wr_tx(9'h0AA);
        tick(20);
        arst_n = 1'b0;
        tick(2);
        chk({txd, tx_data_empty, xck_oe, tx_complete}, 4'hC, "reset");
        arst_n = 1'b1;
        $display("test reset done");
        final_report;
    end
    initial begin
        #1000000;
        fail_count++;
        final_report;
    end
endmodule : ucg_top_tb
